// *** audio_rx_regs.vh ***
`ifndef AUDIO_RX_REGS_VH
`define AUDIO_RX_REGS_VH
// register byte addresses
`define ADR_CTRL 8'h00
`define ADR_FORMAT 8'h04
`define ADR_STATUS 8'h08
`define ADR_WORD 8'h0C
`define ADR_LEFT 8'h10
`define ADR_RIGHT 8'h14
// control fields
`define CTRL_EN 0
`define CTRL_CLK_FALL 1
`define CTRL_DATA_LOW 2
`define CTRL_WS_INV 3
`define CTRL_LSB_FIRST 4
`define CTRL_VAR_LSB 8
`define CTRL_VAR_MSB 9
// variant codes
`define VAR_STD 2'h0
`define VAR_LEFT 2'h1
`define VAR_RIGHT 2'h2
`define VAR_MUX 2'h3
// format fields: word length, channel offset, block length, channel count - 1
`define FMT_WLEN_LSB 0
`define FMT_OFS_LSB 8
`define FMT_BLEN_LSB 16
`define FMT_NCH_LSB 24
// reset values
`define CTRL_RST 32'h0000_0000
`define FMT_RST 32'h0720_0010
`define MAX_LEN 6'h20
`endif

// *** word_store.v ***
`timescale 1ns/1ps
// eight channel word memory, registered read
module word_store (
  // clock
  input wire clk_i,
  // write port
  input wire wr_en_i,
  input wire [2:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  // read port
  input wire [2:0] rd_addr_i,
  output reg [31:0] rd_data_o
);
  reg [31:0] mem_reg [0:7];

  // write and registered read
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule

// *** audio_serial_frame_decoder.v ***
`timescale 1ns/1ps
`include "audio_rx_regs.vh"
module audio_serial_frame_decoder (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // audio link pins
  input wire bit_clock_i,
  input wire frame_channel_strobe_i,
  input wire serial_data_i,
  // word stream out
  output reg word_valid_o,
  output reg [2:0] word_chan_o,
  output reg [31:0] word_data_o
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  reg [1:0] clk_sync_reg;
  reg [1:0] ws_sync_reg;
  reg [1:0] sd_sync_reg;
  reg clk_prev_reg;

  // two flops on each pin; only the second stage feeds logic
  always @(posedge clk_i) begin
    clk_sync_reg <= {clk_sync_reg[0], bit_clock_i};
    ws_sync_reg <= {ws_sync_reg[0], frame_channel_strobe_i};
    sd_sync_reg <= {sd_sync_reg[0], serial_data_i};
    clk_prev_reg <= clk_sync_reg[1];
  end

  // ==========================================================
  // registers
  // ==========================================================
  reg [31:0] ctrl_reg;
  reg [31:0] fmt_reg;
  reg overrun_reg;
  reg frame_err_reg;
  reg cfg_err_reg;
  reg [7:0] frame_count_reg;
  wire enable = ctrl_reg[`CTRL_EN];
  wire clk_fall_sel = ctrl_reg[`CTRL_CLK_FALL];
  wire data_low = ctrl_reg[`CTRL_DATA_LOW];
  wire ws_inv = ctrl_reg[`CTRL_WS_INV];
  wire lsb_first = ctrl_reg[`CTRL_LSB_FIRST];
  wire [1:0] variant = ctrl_reg[`CTRL_VAR_MSB:`CTRL_VAR_LSB];
  wire [5:0] wlen = fmt_reg[`FMT_WLEN_LSB +: 6];
  wire [5:0] ofs = fmt_reg[`FMT_OFS_LSB +: 6];
  wire [5:0] blen = fmt_reg[`FMT_BLEN_LSB +: 6];
  wire [2:0] nch_m1 = fmt_reg[`FMT_NCH_LSB +: 3];
  wire is_mux = (variant == `VAR_MUX);
  // word length 1..block, block covers word plus offset, block at most 32
  wire [6:0] need_len = {1'b0, wlen} + {1'b0, ofs};
  wire cfg_ok = (wlen != 6'h00) && (need_len <= {1'b0, blen}) && (blen <= `MAX_LEN);

  // ==========================================================
  // bit clock edge and sampled levels
  // ==========================================================
  // one sample per chosen bit clock edge
  wire rise = clk_sync_reg[1] & ~clk_prev_reg;
  wire fall = ~clk_sync_reg[1] & clk_prev_reg;
  wire bit_edge = clk_fall_sel ? fall : rise;
  wire ws_now = ws_sync_reg[1];
  wire sd_bit = sd_sync_reg[1] ^ data_low;

  // ==========================================================
  // receive state
  // ==========================================================
  localparam ST_HUNT = 2'h0;
  localparam ST_RUN = 2'h1;
  reg [1:0] state_reg;
  reg ws_last_reg;
  reg [5:0] slot_pos_reg;
  reg [2:0] chan_reg;
  reg [31:0] shift_reg;
  reg [5:0] got_reg;
  reg [31:0] tail_reg;
  reg wr_en_reg;
  reg [2:0] wr_addr_reg;
  reg [31:0] wr_data_reg;

  // strobe edges seen at bit clock edges
  wire ws_rise = ws_now & ~ws_last_reg;
  wire ws_fall = ~ws_now & ws_last_reg;
  wire ws_change = ws_rise | ws_fall;
  // multiplexed start on the selected sync edge only
  wire sync_edge = ws_inv ? ws_fall : ws_rise;
  // channel of the slot that the strobe level now selects
  wire [2:0] pcm_chan = {2'b00, ws_now ^ ws_inv};
  // first word bit position inside the slot
  wire [5:0] first_pos = (variant == `VAR_STD) ? 6'h01 :
    (variant == `VAR_RIGHT) ? 6'h00 : ofs;
  wire in_word = (slot_pos_reg >= first_pos) && (got_reg < wlen);

  // msb first or lsb first word assembly
  function [31:0] put_bit;
    input [31:0] acc;
    input [5:0] idx;
    input low_bit_first;
    input b;
    begin
      put_bit = low_bit_first ? (acc | ({31'h0000_0000, b} << idx)) : {acc[30:0], b};
    end
  endfunction

  // trailing aligned: keep last wlen bits; bit order fixed at close
  function [31:0] tail_word;
    input [31:0] t;
    input [5:0] n;
    input low_bit_first;
    reg [31:0] m;
    reg [31:0] r;
    integer k;
    begin
      m = (n >= 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
      r = 32'h0000_0000;
      for (k = 0; k < 32; k = k + 1) begin
        if (k < n) begin
          r[k] = t[n - 1 - k];
        end
      end
      tail_word = low_bit_first ? r : (t & m);
    end
  endfunction

  // the slot is over at a strobe change (two channel) or at block end (multiplexed)
  // block ends at the edge carrying the next block's first bit, like a strobe change
  wire blk_end = is_mux && (slot_pos_reg == blen);
  wire slot_close = is_mux ? (blk_end || sync_edge) : ws_change;

  // bit-level receive machine
  always @(posedge clk_i) begin
    wr_en_reg <= 1'b0;
    if (!rst_n_i || !enable || !cfg_ok) begin
      state_reg <= ST_HUNT;
      // track the parked strobe level so the first real change after enable is an edge
      ws_last_reg <= ws_now;
      slot_pos_reg <= 6'h00;
      chan_reg <= 3'h0;
      shift_reg <= 32'h0000_0000;
      got_reg <= 6'h00;
      tail_reg <= 32'h0000_0000;
      wr_addr_reg <= 3'h0;
      wr_data_reg <= 32'h0000_0000;
      if (!rst_n_i) begin
        frame_err_reg <= 1'b0;
        frame_count_reg <= 8'h00;
      end
    end else if (bit_edge) begin
      ws_last_reg <= ws_now;
      case (state_reg)
        ST_HUNT: begin
          // wait for a strobe change (two channel) or the selected sync edge (multiplexed) before counting any bit
          if ((is_mux && sync_edge) || (!is_mux && ws_change)) begin
            state_reg <= ST_RUN;
            chan_reg <= is_mux ? 3'h0 : pcm_chan;
            slot_pos_reg <= 6'h01;
            got_reg <= 6'h00;
            shift_reg <= 32'h0000_0000;
            tail_reg <= {31'h0000_0000, sd_bit};
            // leading aligned zero offset: this edge carries bit one
            if (variant == `VAR_LEFT && ofs == 6'h00 && !is_mux) begin
              shift_reg <= put_bit(32'h0000_0000, 6'h00, lsb_first, sd_bit);
              got_reg <= 6'h01;
            end else if (is_mux && ofs == 6'h00) begin
              shift_reg <= put_bit(32'h0000_0000, 6'h00, lsb_first, sd_bit);
              got_reg <= 6'h01;
            end
          end
        end
        ST_RUN: begin
          if (slot_close) begin
            // write out the finished word
            wr_en_reg <= 1'b1;
            wr_addr_reg <= chan_reg;
            wr_data_reg <= (variant == `VAR_RIGHT) ? tail_word(tail_reg, wlen, lsb_first) : shift_reg;
            // a standard or left aligned two channel word shorter than the word length is flagged
            if (!is_mux && variant != `VAR_RIGHT && got_reg < wlen) begin
              frame_err_reg <= 1'b1;
            end
            slot_pos_reg <= 6'h01;
            got_reg <= 6'h00;
            shift_reg <= 32'h0000_0000;
            tail_reg <= {31'h0000_0000, sd_bit};
            if (is_mux) begin
              if (sync_edge) begin
                chan_reg <= 3'h0;
                frame_count_reg <= frame_count_reg + 8'h01;
              end else begin
                chan_reg <= chan_reg + 3'h1;
              end
              if (ofs == 6'h00) begin
                shift_reg <= put_bit(32'h0000_0000, 6'h00, lsb_first, sd_bit);
                got_reg <= 6'h01;
              end
              // channels past the configured count are idle until next sync
              if (!sync_edge && chan_reg == nch_m1) begin
                state_reg <= ST_HUNT;
              end
            end else begin
              chan_reg <= pcm_chan;
              if (variant == `VAR_LEFT && ofs == 6'h00) begin
                shift_reg <= put_bit(32'h0000_0000, 6'h00, lsb_first, sd_bit);
                got_reg <= 6'h01;
              end
              if (ws_now ^ ws_inv) begin
                frame_count_reg <= frame_count_reg + 8'h01;
              end
            end
          end else begin
            // bits past the word or past slot space are dropped
            if (slot_pos_reg != 6'h3F) begin
              slot_pos_reg <= slot_pos_reg + 6'h01;
            end
            tail_reg <= {tail_reg[30:0], sd_bit};
            if (in_word && variant != `VAR_RIGHT) begin
              shift_reg <= put_bit(shift_reg, got_reg, lsb_first, sd_bit);
              got_reg <= got_reg + 6'h01;
            end
          end
        end
        default: begin
          state_reg <= ST_HUNT;
        end
      endcase
    end
  end

  // ==========================================================
  // word memory and stream output
  // ==========================================================
  reg [2:0] rd_addr_reg;
  wire [31:0] rd_data;

  word_store u_store (
    .clk_i(clk_i),
    .wr_en_i(wr_en_reg),
    .wr_addr_i(wr_addr_reg),
    .wr_data_i(wr_data_reg),
    .rd_addr_i(rd_addr_reg),
    .rd_data_o(rd_data)
  );

  // stream pulse alongside the memory write
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      word_valid_o <= 1'b0;
      word_chan_o <= 3'h0;
      word_data_o <= 32'h0000_0000;
    end else begin
      word_valid_o <= wr_en_reg;
      if (wr_en_reg) begin
        word_chan_o <= wr_addr_reg;
        word_data_o <= wr_data_reg;
      end
    end
  end

  // ==========================================================
  // wishbone slave
  // ==========================================================
  // two-cycle answer: read memory address latched first, ack next
  reg pend_reg;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire is_word = (wb_adr_i >= `ADR_WORD) && (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= 8'h2C);
  wire [2:0] word_idx = (wb_adr_i == `ADR_LEFT) ? 3'h0 : (wb_adr_i == `ADR_RIGHT) ? 3'h1 :
    wb_adr_i[4:2] - 3'h3;

  // byte lane merge helper
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // register access; sticky overrun set wins over its clear
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `CTRL_RST;
      fmt_reg <= `FMT_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      pend_reg <= 1'b0;
      rd_addr_reg <= 3'h0;
      overrun_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      cfg_err_reg <= enable & ~cfg_ok;
      if (req && !pend_reg) begin
        pend_reg <= 1'b1;
        rd_addr_reg <= word_idx;
      end else if (req && pend_reg) begin
        pend_reg <= 1'b0;
        wb_ack_o <= 1'b1;
        wb_dat_o <= 32'h0000_0000;
        if (wb_we_i) begin
          if (wb_adr_i == `ADR_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_031F;
          end
          if (wb_adr_i == `ADR_FORMAT) begin
            fmt_reg <= merge(fmt_reg, wb_dat_i, wb_sel_i) & 32'h073F_3F3F;
          end
        end else begin
          case (wb_adr_i)
            `ADR_CTRL: wb_dat_o <= ctrl_reg;
            `ADR_FORMAT: wb_dat_o <= fmt_reg;
            `ADR_STATUS: wb_dat_o <= {16'h0000, frame_count_reg, 3'h0, cfg_err_reg,
              frame_err_reg, overrun_reg, state_reg};
            default: wb_dat_o <= is_word ? rd_data : 32'h0000_0000;
          endcase
        end
      end
      // overrun: a word arrives while software reads the same slot
      if (wr_en_reg && req && pend_reg && !wb_we_i && is_word && rd_addr_reg == wr_addr_reg) begin
        overrun_reg <= 1'b1;
      end else if (req && pend_reg && wb_we_i && wb_adr_i == `ADR_STATUS && wb_sel_i[0] && wb_dat_i[2]) begin
        overrun_reg <= 1'b0;
      end
    end
  end
endmodule

// *** audio_decoder_monitor.sv ***
`timescale 1ns/1ps
`include "audio_rx_regs.vh"
module audio_decoder_monitor (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // link and word stream
  input wire bit_clock_i,
  input wire word_valid_o,
  input wire [2:0] word_chan_o,
  input wire [31:0] word_data_o
);
  logic [31:0] ctrl_reg;
  logic [31:0] fmt_reg;
  logic [3:0] quiet_reg;
  logic bclk_reg;
  wire mux_mode = ctrl_reg[`CTRL_VAR_MSB:`CTRL_VAR_LSB] == `VAR_MUX;
  wire [5:0] wlen = fmt_reg[5:0];
  // ==========================================
  // shadow registers and bit clock idle counter
  // shadow copies let word checks see the live setup
  always @(posedge clk_i) begin
    bclk_reg <= bit_clock_i;
    quiet_reg <= (bit_clock_i != bclk_reg) ? 4'h0 : (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
    if (!rst_n_i) begin
      ctrl_reg <= `CTRL_RST;
      fmt_reg <= `FMT_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `ADR_CTRL)
        ctrl_reg <= wb_dat_i;
      if (wb_adr_i == `ADR_FORMAT)
        fmt_reg <= wb_dat_i;
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence bus_req_s;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence ack_two_s;
    !wb_ack_o ##1 wb_ack_o;
  endsequence
  ack_latency_a: assert property (bus_req_s |=> ack_two_s) else $error("bus answer late or early");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("bus answer too long");
  valid_pulse_a: assert property (word_valid_o |=> !word_valid_o) else $error("word strobe too long");
  link_timed_a: assert property (word_valid_o |-> quiet_reg < 4'ha)
    else $error("word without bit clock activity");
  need_enable_a: assert property (word_valid_o |-> ctrl_reg[`CTRL_EN])
    else $error("word while disabled");
  fmt_legal_a: assert property (word_valid_o |-> wlen != 0 && fmt_reg[21:16] >= 7'(wlen) + 7'(fmt_reg[13:8]))
    else $error("word under illegal format");
  pair_chan_a: assert property (word_valid_o && !mux_mode |-> word_chan_o <= 3'h1)
    else $error("two channel index out of range");
  mux_chan_a: assert property (word_valid_o && mux_mode |-> word_chan_o <= fmt_reg[26:24])
    else $error("mux channel beyond count");
  word_width_a: assert property (word_valid_o |-> (word_data_o >> wlen) == 32'h0000_0000)
    else $error("bits above word length");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !word_valid_o [*8])
    else $error("word right after reset");
endmodule

// *** audio_tx_model.sv ***
`timescale 1ns/1ps
module audio_tx_model (
  // link pins toward the decoder
  output logic bit_clock_o,
  output logic strobe_o,
  output logic data_o
);
  logic fall = 1'b0;
  initial begin
    bit_clock_o = 1'b0;
    strobe_o = 1'b0;
    data_o = 1'b0;
  end
  // park clock between frames; data no longer holds its last value
  task automatic idle(input logic lvl, input logic f);
    fall = f;
    bit_clock_o = f;
    strobe_o = lvl;
    data_o = ~data_o;
    #400;
  endtask
  // one slot, first bit first; data moves on the non-sampling edge so it is stable when taken
  task automatic send(input logic lvl, input logic [31:0] pat, input int n, input logic pulse);
    for (int i = 0; i < n; i++) begin
      strobe_o = (pulse && i > 0) ? ~lvl : lvl;
      data_o = pat[31 - i];
      #200 bit_clock_o = ~fall;
      #200 bit_clock_o = fall;
    end
    data_o = ~data_o;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "audio_rx_regs.vh"
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rd;
  wire bclk, strb, sdat, wb_ack_o, word_valid_o;
  wire [31:0] wb_dat_o, word_data_o;
  wire [2:0] word_chan_o;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 60;
  logic [34:0] got_q[$];
  logic [34:0] exp_q[$];
  always #25 clk_i = ~clk_i;
  audio_serial_frame_decoder u_audio_serial_frame_decoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bit_clock_i(bclk), .frame_channel_strobe_i(strb), .serial_data_i(sdat),
    .word_valid_o(word_valid_o), .word_chan_o(word_chan_o), .word_data_o(word_data_o));
  audio_tx_model u_audio_tx_model (.bit_clock_o(bclk), .strobe_o(strb), .data_o(sdat));
  // collect finished words as {chan, data}; one cycle pulse, so look every cycle
  always @(negedge clk_i) if (word_valid_o === 1'b1) got_q.push_back({word_chan_o, word_data_o});
  // ==========================================
  // helpers
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [34:0] g, input logic [34:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // classic single cycle; request held until the rising edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ack and read data are read at the edge itself, before the design updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(wb_ack_o, 1'b1, "no bus answer");
    if (wb_ack_o !== 1'b1)
      end_sim();
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic [31:0] mask(int wl);
    return 32'((64'h1 << wl) - 1);
  endfunction
  function automatic logic [31:0] place(logic [31:0] pat, logic [31:0] w, int st, int wl, logic low_bit_first);
    for (int i = 0; i < wl; i++)
      if (st + i < 32)
        pat[31 - st - i] = low_bit_first ? w[i] : w[wl - 1 - i];
    return pat;
  endfunction
  task automatic send2(input logic lvl, input logic [31:0] w, input int v, input int wl, input int ofs,
    input logic [3:0] r);
    logic [31:0] pat;
    pat = place($random(seed), w, v == 0 ? 1 : v == 1 ? ofs : 32 - wl, wl, r[3]);
    u_audio_tx_model.send(lvl, r[1] ? ~pat : pat, 32, 1'b0);
  endtask
  // bounded wait for the expected words, then a short quiet spell
  task automatic match();
    int n = 0;
    while (got_q.size() < exp_q.size() && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    repeat (20) @(posedge clk_i);
    chk(got_q.size(), exp_q.size(), "word count");
    foreach (exp_q[i])
      if (i < got_q.size())
        chk(got_q[i], exp_q[i], "word value");
    got_q.delete();
    exp_q.delete();
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] wa, wb_w, pat;
    logic [3:0] r;
    int v, wl, ofs, nc, bl, w;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wb(1'b0, `ADR_CTRL, 32'h0000_0000, rd);
    chk(rd, `CTRL_RST, "ctrl reset value");
    wb(1'b0, `ADR_FORMAT, 32'h0000_0000, rd);
    chk(rd, `FMT_RST, "format reset value");
    wb(1'b1, 8'h80, 32'hffff_ffff, rd);
    wb(1'b0, 8'h80, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    // two channel variants; first cases hit word length 1, 31 and a full 32 bit slot
    for (int it = 0; it < 9; it++) begin
      v = it % 3;
      wl = (it == 0) ? 1 : (it < 3) ? 30 + it : 1 + $unsigned($random(seed)) % 31;
      ofs = (v == 1) ? $unsigned($random(seed)) % (33 - wl) : 0;
      r = $random(seed);
      wa = $random(seed);
      wb_w = $random(seed);
      wb(1'b1, `ADR_CTRL, 32'h0000_0000, rd);
      wb(1'b1, `ADR_FORMAT, {8'h01, 2'h0, 6'd32, 2'h0, 6'(ofs), 2'h0, 6'(wl)}, rd);
      u_audio_tx_model.idle(~r[2], r[0]);
      wb(1'b1, `ADR_CTRL, {22'h0, 2'(v), 3'h0, r, 1'b1}, rd);
      exp_q.push_back({3'h0, wa & mask(wl)});
      exp_q.push_back({3'h1, wb_w & mask(wl)});
      send2(r[2], wa, v, wl, ofs, r);
      send2(~r[2], wb_w, v, wl, ofs, r);
      u_audio_tx_model.send(r[2], $random(seed), 2, 1'b0);
      match();
    end
    // mux frames: 3 of 4 blocks used, 8 blocks, then an illegal length that must stay silent
    for (int j = 0; j < 3; j++) begin
      nc = j ? 8 : 3;
      bl = j ? 4 : 8;
      w = (j == 1) ? 3 : j ? 4 : 7;
      r = $random(seed);
      pat = $random(seed);
      wb(1'b1, `ADR_CTRL, 32'h0000_0000, rd);
      wb(1'b1, `ADR_FORMAT, {5'h0, 3'(nc - 1), 2'h0, 6'(bl), 2'h0, 6'd1, 2'h0, 6'(w)}, rd);
      u_audio_tx_model.idle(r[2], r[0]);
      wb(1'b1, `ADR_CTRL, {22'h0, 2'h3, 3'h0, r, 1'b1}, rd);
      for (int k = 0; k < 32 / bl; k++) begin
        wa = $random(seed);
        pat = place(pat, wa, k * bl + 1, w, r[3]);
        if (k < nc && j < 2)
          exp_q.push_back({3'(k), wa & mask(w)});
      end
      u_audio_tx_model.send(~r[2], r[1] ? ~pat : pat, 32, 1'b1);
      // next sync pulse gives the edge that closes the last block of a full frame
      u_audio_tx_model.send(~r[2], $random(seed), 2, 1'b1);
      match();
      if (j == 2) begin
        wb(1'b0, `ADR_STATUS, 32'h0000_0000, rd);
        chk(rd[4], 1'b1, "illegal length not flagged");
      end
    end
    end_sim();
  end
endmodule
bind audio_serial_frame_decoder audio_decoder_monitor u_audio_decoder_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .bit_clock_i(bit_clock_i), .word_valid_o(word_valid_o), .word_chan_o(word_chan_o),
  .word_data_o(word_data_o));
